/* hdl/atf_task_file_port.sv */
`timescale 1ns/10ps
// Overview of operation
// [R1] Control/status word takes single-byte accesses only
// [R2] Control word upper byte, low half read zero
// [R3] Lane two write loads device control
// [R4] Lane two read returns auxiliary status
// [R5] Read-ahead port: 8/16/32-bit, lane-zero aligned
// [R6] Lane zero enable alone means byte data
// [R7] Lanes one and three mean halfword data
// [R8] All four lanes mean full word data
// [R9] Sector number only with lane three enable
// [R10] Sector count only with lane two enable
// [R11] Lane one write loads write-only features
// [R12] Lane one read returns read-only error
// [R13] Second word top byte write loads command
// [R14] Second word top byte read returns status
// [R15] Device/head byte is read/write
// [R16] Cylinder high and low bytes read/write
// [R17] Word after buffered pair reads as don't-care
// [R18] Buffered pair is the command-buffered path
// [R19] Command-active flag set on command, cleared after
// [R20] Read-ahead count uses low sixteen bits only
// [R21] Buffered bytes forwarded ascending, command last
module atf_task_file_port #(
  parameter int BUF_DEPTH = 2
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [3:0] reg_be,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  input wire atf_pkg::atf_drv_stat_type drv_stat,
  output logic ata_wr_valid,
  input wire logic ata_wr_ready,
  output atf_pkg::atf_ata_wr_type ata_wr,
  input wire logic ra_valid,
  output logic ra_ready,
  input wire logic [31:0] ra_data,
  output logic cmd_active,
  output logic [15:0] ra_count_pio
);

  localparam int EW = $bits(atf_pkg::atf_ata_wr_type);

  atf_pkg::atf_drv_stat_type stat_s;
  atf_pkg::atf_ata_wr_type in_entry;
  logic [7:0] tf_byte [7];
  logic [31:0] data_shadow;
  logic [31:0] ra_count;
  logic [6:0] pend;
  logic [6:0] next_pend;
  logic [2:0] pend_idx;
  logic in_valid;
  logic in_ready;
  logic take;
  logic stall;
  logic go;
  logic hit_ctrl;
  logic hit_ra;
  logic hit_lo;
  logic hit_hi;
  logic hit_rsvd;
  logic hit_cnt;
  logic be_one;
  logic be_data;
  logic direct_push;
  logic cmd_out;
  logic [1:0] be_size;

  // ==========================================================
  // Drive status arrives from pins; caught through two stages
  atf_sync2 #(
    .W($bits(atf_pkg::atf_drv_stat_type))
  ) u_stat_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .async_in(drv_stat),
    .sync_out(stat_s)
  );

  // ==========================================================
  // Address and byte enable decode
  assign hit_ctrl = (reg_addr == atf_pkg::ATF_CTRL_OFS);
  assign hit_ra = (reg_addr == atf_pkg::ATF_RA_DATA_OFS);
  assign hit_lo = (reg_addr == atf_pkg::ATF_BUF_LO_OFS);
  assign hit_hi = (reg_addr == atf_pkg::ATF_BUF_HI_OFS);
  assign hit_rsvd = (reg_addr == atf_pkg::ATF_RSVD_OFS);
  assign hit_cnt = (reg_addr == atf_pkg::ATF_RA_CNT_OFS);
  assign be_one = $onehot(reg_be); // R1
  // Both halfword patterns taken; the printed one may be a misprint
  assign be_data = (reg_be == atf_pkg::ATF_BE_BYTE) || // R6
                   (reg_be == atf_pkg::ATF_BE_HALF) || // R7
                   (reg_be == atf_pkg::ATF_BE_HALF_ALT) ||
                   (reg_be == atf_pkg::ATF_BE_WORD); // R8

  // Data width from the enables, always lane-zero aligned
  always_comb begin
    if (reg_be == atf_pkg::ATF_BE_WORD) begin
      be_size = atf_pkg::ATF_SIZE_WORD;
    end else if (reg_be == atf_pkg::ATF_BE_BYTE) begin
      be_size = atf_pkg::ATF_SIZE_BYTE;
    end else begin
      be_size = atf_pkg::ATF_SIZE_HALF;
    end
  end

  // ==========================================================
  // Request acceptance; writes that feed the drive wait for room
  assign take = reg_req && !reg_ack && ce;
  always_comb begin
    if (!reg_wr && hit_ra) begin
      stall = !ra_valid;
    end else if (reg_wr && (hit_ctrl || hit_ra || hit_lo || hit_hi)) begin
      stall = (pend != atf_pkg::ATF_PEND_RST) || !in_ready;
    end else begin
      stall = 1'b0;
    end
  end
  assign go = take && !stall;
  assign ra_ready = go && !reg_wr && hit_ra; // R5

  // Immediate pushes: device control, read-ahead and buffered data
  always_comb begin
    direct_push = 1'b0;
    in_entry.sel = atf_pkg::ATF_SEL_DATA;
    in_entry.size = be_size;
    in_entry.data = reg_wdata;
    if (go && reg_wr && hit_ctrl && be_one && reg_be[2]) begin
      direct_push = 1'b1; // R3
      in_entry.sel = atf_pkg::ATF_SEL_DEVCTL;
      in_entry.size = atf_pkg::ATF_SIZE_BYTE;
      in_entry.data = {24'h00_0000, reg_wdata[23:16]};
    end else if (go && reg_wr && (hit_ra || hit_lo) && be_data) begin
      direct_push = 1'b1; // R5
    end else if (pend != atf_pkg::ATF_PEND_RST) begin
      in_entry.sel = atf_pkg::atf_sel_type'({1'b0, pend_idx}); // R21
      in_entry.size = atf_pkg::ATF_SIZE_BYTE;
      in_entry.data = {24'h00_0000, tf_byte[pend_idx]};
    end
  end
  assign in_valid = direct_push || (pend != atf_pkg::ATF_PEND_RST);

  // Lowest pending byte first; command sits at the top index
  always_comb begin
    pend_idx = 3'(atf_pkg::ATF_CMD_IDX);
    for (int i = atf_pkg::ATF_CMD_IDX; i >= 0; i--) begin
      if (pend[i]) begin
        pend_idx = 3'(i); // R21
      end
    end
  end

  // ==========================================================
  // Buffer toward the drive so a stalled drive loses no byte
  atf_pipe_buf #(
    .W(EW),
    .DEPTH(BUF_DEPTH)
  ) u_wr_buf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_entry),
    .out_valid(ata_wr_valid),
    .out_ready(ata_wr_ready),
    .out_data(ata_wr)
  );

  // ==========================================================
  // Pending mask: buffered lane writes queue, pushes retire them
  always_comb begin
    next_pend = pend;
    if (in_valid && in_ready && !direct_push) begin
      next_pend[pend_idx] = 1'b0;
    end
    if (go && reg_wr && hit_lo && !be_data) begin
      next_pend[0] = reg_be[1]; // R11
      next_pend[1] = reg_be[2]; // R10
      next_pend[2] = reg_be[3]; // R9
    end else if (go && reg_wr && hit_hi) begin
      next_pend[3] = reg_be[0]; // R16
      next_pend[4] = reg_be[1]; // R16
      next_pend[5] = reg_be[2]; // R15
      next_pend[6] = reg_be[3]; // R13
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend <= atf_pkg::ATF_PEND_RST;
    end else if (ce) begin
      pend <= next_pend;
    end
  end

  // Shadow task-file bytes, each only under its own lane
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i <= atf_pkg::ATF_CMD_IDX; i++) begin
        tf_byte[i] <= atf_pkg::ATF_BYTE_RST;
      end
      data_shadow <= atf_pkg::ATF_WORD_RST;
    end else if (go && reg_wr && hit_lo) begin
      if (be_data) begin
        data_shadow <= reg_wdata; // R18
      end else begin
        for (int i = 1; i < 4; i++) begin
          if (reg_be[i]) begin
            tf_byte[i - 1] <= reg_wdata[8 * i +: 8]; // R9
          end
        end
      end
    end else if (go && reg_wr && hit_hi) begin
      for (int i = 0; i < 4; i++) begin
        if (reg_be[i]) begin
          tf_byte[i + 3] <= reg_wdata[8 * i +: 8]; // R13
        end
      end
    end
  end

  // ==========================================================
  // Command-active flag; a new command wins over the clear
  assign cmd_out = ata_wr_valid && ata_wr_ready && (ata_wr.sel == atf_pkg::ATF_SEL_CMD);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_active <= 1'b0;
    end else if (ce) begin
      if (go && reg_wr && hit_hi && reg_be[3]) begin
        cmd_active <= 1'b1; // R19
      end else if (cmd_out) begin
        cmd_active <= 1'b0; // R19
      end
    end
  end

  // Read-ahead count; PIO mode sees the low half only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ra_count <= atf_pkg::ATF_WORD_RST;
    end else if (go && reg_wr && hit_cnt) begin
      for (int i = 0; i < 4; i++) begin
        if (reg_be[i]) begin
          ra_count[8 * i +: 8] <= reg_wdata[8 * i +: 8];
        end
      end
    end
  end
  assign ra_count_pio = ra_count[atf_pkg::ATF_RA_CNT_USED-1:0]; // R20

  // ==========================================================
  // Read data and acknowledge, one cycle after acceptance
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= atf_pkg::ATF_WORD_RST;
      reg_ack <= 1'b0;
    end else if (ce) begin
      reg_ack <= go;
      if (go && !reg_wr) begin
        reg_rdata <= atf_pkg::ATF_WORD_RST;
        if (hit_ctrl && be_one && reg_be[2]) begin
          reg_rdata[23:16] <= stat_s.alt_status; // R4 R2
        end else if (hit_ra) begin
          reg_rdata <= ra_data; // R5
        end else if (hit_lo && be_data) begin
          reg_rdata <= data_shadow; // R8
        end else if (hit_lo) begin
          reg_rdata <= {reg_be[3] ? tf_byte[2] : 8'h00, // R9
                        reg_be[2] ? tf_byte[1] : 8'h00, // R10
                        reg_be[1] ? stat_s.error : 8'h00, 8'h00}; // R12
        end else if (hit_hi) begin
          reg_rdata <= {stat_s.status, tf_byte[5], tf_byte[4], tf_byte[3]}; // R14 R15 R16
        end else if (hit_cnt) begin
          reg_rdata <= ra_count;
        end
        // Reserved word and unmapped offsets read zero (R17)
      end
    end
  end

  // ==========================================================
  // Checks
  ctrl_reserved_zero_a: assert property ( // R2
    @(posedge ref_clk) disable iff (!rst_n)
    go && !reg_wr && hit_ctrl |=> reg_rdata[31:24] == 8'h00 && reg_rdata[15:0] == 16'h0000)
    else $error("control word reserved bits not zero");

  altstat_read_a: assert property ( // R4
    @(posedge ref_clk) disable iff (!rst_n)
    go && !reg_wr && hit_ctrl && reg_be == 4'h4 |=>
      reg_ack && reg_rdata[23:16] == $past(stat_s.alt_status))
    else $error("aux status not returned");

  devctl_push_a: assert property ( // R3
    @(posedge ref_clk) disable iff (!rst_n)
    go && reg_wr && hit_ctrl && reg_be == 4'h4 |->
      in_valid && in_entry.sel == atf_pkg::ATF_SEL_DEVCTL && in_entry.data[7:0] == reg_wdata[23:16])
    else $error("device control not forwarded");

  ctrl_multi_be_a: assert property ( // R1
    @(posedge ref_clk) disable iff (!rst_n)
    go && reg_wr && hit_ctrl && reg_be != 4'h4 |-> !direct_push)
    else $error("multi-byte control write acted on");

  features_load_a: assert property ( // R11
    @(posedge ref_clk) disable iff (!rst_n)
    go && reg_wr && hit_lo && reg_be == 4'h2 |=> pend[0] && tf_byte[0] == $past(reg_wdata[15:8]))
    else $error("features byte not queued");

  secnum_lane_a: assert property ( // R9
    @(posedge ref_clk) disable iff (!rst_n)
    go && reg_wr && hit_lo && reg_be == 4'h8 |=> pend == 7'h04)
    else $error("sector number queue wrong");

  status_read_a: assert property ( // R14
    @(posedge ref_clk) disable iff (!rst_n)
    go && !reg_wr && hit_hi |=> reg_rdata[31:24] == $past(stat_s.status))
    else $error("status not returned");

  cmd_last_a: assert property ( // R21
    @(posedge ref_clk) disable iff (!rst_n)
    in_valid && in_ready && in_entry.sel == atf_pkg::ATF_SEL_CMD |-> pend[5:0] == 6'h00)
    else $error("command forwarded before other bytes");

  cmd_flag_a: assert property ( // R19
    @(posedge ref_clk) disable iff (!rst_n)
    go && reg_wr && hit_hi && reg_be[3] |=> cmd_active ##1 (cmd_active || $past(cmd_out)))
    else $error("command flag not held");

  ra_count_low_a: assert property ( // R20
    @(posedge ref_clk) disable iff (!rst_n)
    go && reg_wr && hit_cnt && reg_be == 4'hf |=> ra_count_pio == $past(reg_wdata[15:0]))
    else $error("read-ahead count low half wrong");

  rsvd_read_a: assert property ( // R17
    @(posedge ref_clk) disable iff (!rst_n)
    go && !reg_wr && hit_rsvd |=> reg_rdata == 32'h0000_0000)
    else $error("reserved word not zero");

endmodule : atf_task_file_port

/* hdl/atf_pkg.sv */
package atf_pkg;

  // ==========================================================
  // Register word offsets of the task-file window
  localparam logic [7:0] ATF_CTRL_OFS = 8'hc8;
  localparam logic [7:0] ATF_RA_DATA_OFS = 8'hcc;
  localparam logic [7:0] ATF_BUF_LO_OFS = 8'hd0;
  localparam logic [7:0] ATF_BUF_HI_OFS = 8'hd4;
  localparam logic [7:0] ATF_RSVD_OFS = 8'hd8;
  localparam logic [7:0] ATF_RA_CNT_OFS = 8'hdc;

  // ==========================================================
  // Reset values and field positions
  localparam logic [31:0] ATF_WORD_RST = 32'h0000_0000;
  localparam logic [7:0] ATF_BYTE_RST = 8'h00;
  localparam logic [6:0] ATF_PEND_RST = 7'h00;
  localparam int ATF_RA_CNT_USED = 16;
  localparam int ATF_CMD_IDX = 6;

  // ==========================================================
  // Byte enable patterns for buffered data accesses
  localparam logic [3:0] ATF_BE_BYTE = 4'h1;
  localparam logic [3:0] ATF_BE_HALF = 4'ha;
  localparam logic [3:0] ATF_BE_HALF_ALT = 4'h3;
  localparam logic [3:0] ATF_BE_WORD = 4'hf;

  // ==========================================================
  // Access size codes carried to the drive side
  localparam logic [1:0] ATF_SIZE_BYTE = 2'h0;
  localparam logic [1:0] ATF_SIZE_HALF = 2'h1;
  localparam logic [1:0] ATF_SIZE_WORD = 2'h2;

  // Drive-side register selects; 0..6 follow forwarding order
  typedef enum logic [3:0] {
    ATF_SEL_FEAT = 4'h0,
    ATF_SEL_SECCNT = 4'h1,
    ATF_SEL_SECNUM = 4'h2,
    ATF_SEL_CYLLO = 4'h3,
    ATF_SEL_CYLHI = 4'h4,
    ATF_SEL_DEVHEAD = 4'h5,
    ATF_SEL_CMD = 4'h6,
    ATF_SEL_DATA = 4'h7,
    ATF_SEL_DEVCTL = 4'h8
  } atf_sel_type;

  typedef struct packed {
    atf_sel_type sel;
    logic [1:0] size;
    logic [31:0] data;
  } atf_ata_wr_type;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] error;
    logic [7:0] alt_status;
  } atf_drv_stat_type;

endpackage : atf_pkg

/* hdl/atf_sync2.sv */
`timescale 1ns/10ps
module atf_sync2 #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta;

  // ==========================================================
  // Two-stage catch; only the second stage is read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule : atf_sync2

/* hdl/atf_pipe_buf.sv */
`timescale 1ns/10ps
module atf_pipe_buf #(
  parameter int W = 38,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] fill;
  logic push;
  logic pop;

  // Honest flags; stalls come straight from the fill count
  assign in_ready = (fill != (PW + 1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready && ce;
  assign pop = out_valid && out_ready && ce;

  // ==========================================================
  // Storage, written only on an accepted push
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap at the depth, not at a power of two
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        fill <= fill + 1'b1;
      end else if (pop && !push) begin
        fill <= fill - 1'b1;
      end
    end
  end

endmodule : atf_pipe_buf

/* verif/atf_drive_model.sv */
`timescale 1ns/10ps
// ==========================================================
// Drive side: accepts forwarded writes, supplies status and read-ahead
module atf_drive_model #(
  parameter logic [7:0] ST = 8'h50,
  parameter logic [7:0] ER = 8'h04,
  parameter logic [7:0] AS = 8'h51,
  parameter logic [31:0] RA0 = 32'h1122_3344
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic ata_wr_valid,
  output logic ata_wr_ready,
  output atf_pkg::atf_drv_stat_type drv_stat,
  output logic ra_valid,
  input wire logic ra_ready,
  output logic [31:0] ra_data
);
  int seed = 31;
  // Status held still so the two-flop sync never sees a change
  assign drv_stat = '{status: ST, error: ER, alt_status: AS};
  // Random stalls when slow: fills the buffer and starves read-ahead
  always @(posedge ref_clk) begin
    #1 ata_wr_ready = slow ? 1'($random(seed)) : 1'b1;
    ra_valid = slow ? 1'($random(seed)) : 1'b1;
  end
  // Next read-ahead word once one is taken
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) ra_data <= RA0;
    else if (ra_ready) ra_data <= ra_data + 32'h0101_0101;
  end
endmodule : atf_drive_model

/* verif/tb_ata_task_file_port.sv */
`timescale 1ns/10ps
module tb_ata_task_file_port;
  localparam logic [7:0] ST = 8'h50;
  localparam logic [7:0] ER = 8'h04;
  localparam logic [7:0] AS = 8'h51;
  localparam logic [31:0] RA0 = 32'h1122_3344;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_req = 1'b0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [3:0] reg_be = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic reg_ack;
  logic ata_wr_valid;
  logic ata_wr_ready;
  logic ra_valid;
  logic ra_ready;
  logic [31:0] ra_data;
  logic cmd_active;
  logic [15:0] ra_count_pio;
  logic slow = 1'b0;
  logic ce = 1'b1;
  atf_pkg::atf_drv_stat_type drv_stat;
  atf_pkg::atf_ata_wr_type ata_wr;
  atf_pkg::atf_ata_wr_type exp_q[$];
  logic [31:0] mask_q[$];
  logic [7:0] tf[8];
  logic [31:0] ra_exp = RA0;
  logic [31:0] q;
  int n_errors = 0;
  int n_tests = 0;
  int seed = 31;
  int i;

  always #5 ref_clk = ~ref_clk;

  atf_task_file_port dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .reg_req(reg_req),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .drv_stat(drv_stat),
    .ata_wr_valid(ata_wr_valid), .ata_wr_ready(ata_wr_ready), .ata_wr(ata_wr),
    .ra_valid(ra_valid), .ra_ready(ra_ready), .ra_data(ra_data),
    .cmd_active(cmd_active), .ra_count_pio(ra_count_pio));
  atf_drive_model #(.ST(ST), .ER(ER), .AS(AS), .RA0(RA0)) drv_u (.ref_clk(ref_clk),
    .rst_n(rst_n), .slow(slow), .ata_wr_valid(ata_wr_valid), .ata_wr_ready(ata_wr_ready),
    .drv_stat(drv_stat), .ra_valid(ra_valid), .ra_ready(ra_ready), .ra_data(ra_data));

  // ==========================================================
  // Checking and bookkeeping
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task finish_test;
    if (n_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  task push(input int s, input logic [1:0] sz, input logic [31:0] d, input logic [31:0] m);
    atf_pkg::atf_ata_wr_type e;
    e.sel = atf_pkg::atf_sel_type'(s);
    e.size = sz;
    e.data = d;
    exp_q.push_back(e);
    mask_q.push_back(m);
  endtask : push

  // Reference model of what each write should forward and store
  task model_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    if (a == 8'hc8 && be == 4'h4) push(8, atf_pkg::ATF_SIZE_BYTE, {24'h0, d[23:16]}, '1);
    if ((a == 8'hcc || a == 8'hd0) && be == 4'hf) push(7, atf_pkg::ATF_SIZE_WORD, d, '1);
    if ((a == 8'hcc || a == 8'hd0) && (be == 4'ha || be == 4'h3))
      push(7, atf_pkg::ATF_SIZE_HALF, d, 32'h0000_ffff);
    if ((a == 8'hcc || a == 8'hd0) && be == 4'h1) push(7, atf_pkg::ATF_SIZE_BYTE, d, 32'hff);
    if (a == 8'hd0 && be != 4'hf && be != 4'ha && be != 4'h3 && be != 4'h1) begin
      for (int k = 1; k < 4; k++) begin
        if (be[k]) begin
          push(k - 1, atf_pkg::ATF_SIZE_BYTE, {24'h0, d[8*k +: 8]}, '1);
          tf[k - 1] = d[8*k +: 8];
        end
      end
    end
    if (a == 8'hd4) begin
      for (int k = 0; k < 4; k++) begin
        if (be[k]) begin
          push(k + 3, atf_pkg::ATF_SIZE_BYTE, {24'h0, d[8*k +: 8]}, '1);
          tf[k + 3] = d[8*k +: 8];
        end
      end
    end
  endtask : model_wr

  // One register access, held until the acknowledge is seen
  task acc(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    int k;
    reg_wr = wr;
    reg_addr = a;
    reg_be = be;
    reg_wdata = d;
    reg_req = 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      #1 k++;
    end while (reg_ack !== 1'b1 && k < 300);
    if (k >= 300) n_errors++;
    q = reg_rdata;
    reg_req = 1'b0;
    reg_wdata = ~d;
    if (wr) model_wr(a, be, d);
    // One idle edge so the next request never re-raises in this step
    @(posedge ref_clk);
    #1;
  endtask : acc

  // Drive-side monitor: every accepted entry in expected order
  always @(posedge ref_clk) begin
    if (rst_n && ata_wr_valid === 1'b1 && ata_wr_ready === 1'b1) begin
      if (exp_q.size() == 0) chk("spurious entry", ata_wr.sel, 32'hff);
      else begin
        chk("entry sel", ata_wr.sel, exp_q[0].sel);
        chk("entry size", ata_wr.size, exp_q[0].size);
        chk("entry data", ata_wr.data & mask_q[0], exp_q[0].data & mask_q[0]);
        void'(exp_q.pop_front());
        void'(mask_q.pop_front());
      end
    end
  end

  task drain;
    for (int k = 0; k < 500 && exp_q.size() > 0; k++) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
    #1 chk("queue left", exp_q.size(), 0);
  endtask : drain

  // Hang guard
  initial begin
    #400000;
    n_errors++;
    finish_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    chk("cmd after reset", cmd_active, 1'b0);
    acc(0, 8'hdc, 4'hf, 0);
    chk("count reset", q, 32'h0);
    acc(1, 8'hdc, 4'hf, 32'h0000_1234);
    acc(0, 8'hdc, 4'hf, 0);
    chk("count rw", q, 32'h0000_1234);
    chk("count pio", ra_count_pio, 16'h1234);
    // Low clock enable must hold a pending read unanswered
    ce = 1'b0;
    fork
      acc(0, 8'hdc, 4'hf, 0);
      begin
        repeat (3) @(posedge ref_clk);
        #1 chk("frozen ack", reg_ack, 1'b0);
        ce = 1'b1;
      end
    join
    chk("count after freeze", q, 32'h0000_1234);
    acc(1, 8'hc8, 4'h4, 32'h00a5_0000);
    acc(0, 8'hc8, 4'h4, 0);
    chk("aux status", q, {8'h00, AS, 16'h0000});
    acc(0, 8'hc8, 4'h2, 0);
    chk("ctrl lane one", q, 32'h0);
    acc(0, 8'hc8, 4'h8, 0);
    chk("ctrl upper", q, 32'h0);
    acc(1, 8'hc8, 4'h1, 32'hffff_ffff);
    acc(1, 8'hd0, 4'h2, 32'h0000_1100);
    acc(1, 8'hd0, 4'h4, 32'h0022_0000);
    acc(1, 8'hd0, 4'h8, 32'h3300_0000);
    acc(0, 8'hd0, 4'h4, 0);
    chk("sector count", q[23:16], 8'h22);
    acc(0, 8'hd0, 4'h8, 0);
    chk("sector number", q[31:24], 8'h33);
    acc(0, 8'hd0, 4'h2, 0);
    chk("error", q[15:8], ER);
    acc(1, 8'hd0, 4'h1, 32'hdead_be01);
    acc(1, 8'hd0, 4'ha, 32'hdead_be02);
    acc(1, 8'hd0, 4'h3, 32'hdead_be03);
    acc(1, 8'hd0, 4'hf, 32'hdead_be04);
    acc(1, 8'hcc, 4'hf, 32'h0bad_f00d);
    acc(1, 8'hcc, 4'h1, 32'h0000_0077);
    for (i = 0; i < 3; i++) begin
      acc(0, 8'hcc, 4'hf, 0);
      chk("read ahead", q, ra_exp);
      ra_exp = ra_exp + 32'h0101_0101;
    end
    acc(1, 8'hd8, 4'hf, 32'hffff_ffff);
    acc(0, 8'hd8, 4'hf, 0);
    chk("reserved", q, 32'h0);
    acc(0, 8'h40, 4'hf, 0);
    chk("unmapped", q, 32'h0);
    drain();
    // Stalling drive: buffer fills, command flag spans the forwarding
    slow = 1'b1;
    acc(1, 8'hd4, 4'hf, 32'hec01_0203);
    chk("cmd active", cmd_active, 1'b1);
    drain();
    chk("cmd cleared", cmd_active, 1'b0);
    for (i = 0; i < 20; i++) begin
      acc(1, ($random(seed) & 1) ? 8'hd4 : 8'hd0, 4'h1 << ($random(seed) & 3), $random(seed));
    end
    drain();
    acc(0, 8'hcc, 4'hf, 0);
    chk("read ahead stalled", q, ra_exp);
    acc(0, 8'hd4, 4'hf, 0);
    chk("second word", q, {ST, tf[5], tf[4], tf[3]});
    acc(0, 8'hd4, 4'h7, 0);
    chk("devhead cyl", q[23:0], {tf[5], tf[4], tf[3]});
    acc(0, 8'hd0, 4'hc, 0);
    chk("buffered lo", q[31:16], {tf[2], tf[1]});
    finish_test();
  end
endmodule : tb_ata_task_file_port
